// ---- rtl/link_monitor_pkg.sv ----
// Constants, field layouts and types shared by the link message monitor.
package link_monitor_pkg;
  // ==========================================================================
  // Channel and message limits
  localparam int unsigned NUM_CHANNELS    = 4;
  localparam int unsigned MAX_MESSAGES    = 127;
  localparam int unsigned MAX_DATA_BYTES  = 65;
  localparam int unsigned KEY_BITS        = 6;
  localparam int unsigned NUM_KEYS        = 64;
  localparam int unsigned POS_BITS        = 7;
  // ==========================================================================
  // Header field positions
  localparam int unsigned HDR_ID_MSB      = 15;
  localparam int unsigned HDR_ID_LSB      = 11;
  localparam int unsigned HDR_ORIGIN_BIT  = 10;
  localparam int unsigned HDR_FRESH_MSB   = 9;
  localparam int unsigned HDR_FRESH_LSB   = 6;
  localparam int unsigned HDR_LEN_MSB     = 5;
  localparam int unsigned HDR_LEN_LSB     = 0;
  localparam int unsigned HDR_FIRST_POS   = 0;
  localparam int unsigned HDR_SECOND_POS  = 1;
  localparam int unsigned DATA_FIRST_POS  = 2;
  // ==========================================================================
  // Line timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned BIT_TIME_NS     = 1000;
  localparam int unsigned GAP_BITS        = 11;
  localparam int unsigned BIT_CYCLES      = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned GAP_CYCLES      = GAP_BITS * BIT_CYCLES - HALF_BIT_CYCLES;
  localparam int unsigned TICK_BITS       = 16;
  // ==========================================================================
  // Output word layout: channel, kind, payload
  localparam int unsigned PAYLOAD_BITS    = 16;
  localparam int unsigned KIND_BITS       = 2;
  localparam int unsigned CHAN_BITS       = 2;
  localparam int unsigned WORD_BITS       = CHAN_BITS + KIND_BITS + PAYLOAD_BITS;
  localparam int unsigned FIFO_DEPTH      = 8;
  localparam logic [1:0]  KIND_HEADER     = 2'h0;
  localparam logic [1:0]  KIND_DATA       = 2'h1;
  localparam logic [1:0]  KIND_END        = 2'h2;
  // ==========================================================================
  // Receiver states
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;
endpackage

// ---- rtl/word_fifo_if.sv ----
// Valid/ready carrier between the monitor core and its output FIFO.
interface word_fifo_if #(parameter int unsigned WIDTH = 8);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : word_fifo_if

// ---- rtl/word_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides.
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic  sys_clk_i,
  input  wire logic  reset_i,
  input  wire logic  ce_i,
  word_fifo_if.fifo  port
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        push;
  logic        pop;

  // ==========================================================================
  // Handshake
  assign port.wr_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign port.rd_valid = (st_reg.count != '0);
  assign port.rd_data  = st_reg.mem[st_reg.rd_ptr];
  assign push          = port.wr_valid && port.wr_ready;
  assign pop           = port.rd_valid && port.rd_ready;

  // ==========================================================================
  // Storage and pointers
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = port.wr_data;
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(st_reg.wr_ptr + 1'b1);
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(st_reg.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      st_next.count = (AW+1)'(st_reg.count + 1'b1);
    end else if (pop && !push) begin
      st_next.count = (AW+1)'(st_reg.count - 1'b1);
    end
    if (reset_i) begin
      st_next = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || ce_i) begin
      st_reg <= st_next;
    end
  end
endmodule // word_fifo

// ---- rtl/link_message_monitor.sv ----
// Four-channel passive monitor that frames and decodes link messages.
module link_message_monitor
  import link_monitor_pkg::*;
(
  input  wire logic                                  sys_clk_i,
  input  wire logic                                  reset_i,
  input  wire logic                                  ce_i,
  input  wire logic [link_monitor_pkg::NUM_CHANNELS-1:0] line_i,
  output logic                                       msg_valid_o,
  input  wire logic                                  msg_ready_i,
  output logic [link_monitor_pkg::CHAN_BITS-1:0]     msg_channel_o,
  output logic [link_monitor_pkg::KIND_BITS-1:0]     msg_kind_o,
  output logic [link_monitor_pkg::PAYLOAD_BITS-1:0]  msg_payload_o,
  output logic [link_monitor_pkg::NUM_CHANNELS-1:0]  overrun_o,
  output logic [link_monitor_pkg::NUM_CHANNELS-1:0]  in_message_o
);
  import link_monitor_pkg::*;

  typedef struct packed {
    logic [2:0]                        sync;
    logic                              line;
    rx_state_t                         rx;
    logic [TICK_BITS-1:0]              tick;
    logic [2:0]                        bit_idx;
    logic [7:0]                        shift;
    logic [TICK_BITS-1:0]              idle;
    logic                              in_msg;
    logic [POS_BITS-1:0]               pos;
    logic [7:0]                        hdr_hi;
    logic                              admit;
    logic [NUM_KEYS-1:0]               seen;
    logic [POS_BITS-1:0]               distinct;
    logic                              pend_valid;
    logic [KIND_BITS+PAYLOAD_BITS-1:0] pend_word;
    logic                              overrun;
  } chan_state_t;

  typedef struct packed {
    chan_state_t [NUM_CHANNELS-1:0] ch;
  } mon_state_t;

  mon_state_t st_reg;
  mon_state_t st_next;
  logic [CHAN_BITS-1:0] grant_idx;
  logic                 grant_any;

  word_fifo_if #(.WIDTH(WORD_BITS)) fifo_port ();

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .port      (fifo_port.fifo)
  );

  // ==========================================================================
  // Helper functions
  function automatic logic [KEY_BITS-1:0] header_key(input logic [15:0] hdr);
    header_key = {hdr[HDR_ID_MSB:HDR_ID_LSB], hdr[HDR_ORIGIN_BIT]};
  endfunction

  function automatic logic [KIND_BITS+PAYLOAD_BITS-1:0] make_word(
    input logic [KIND_BITS-1:0]    kind,
    input logic [PAYLOAD_BITS-1:0] payload
  );
    make_word = {kind, payload};
  endfunction

  // ==========================================================================
  // Output arbitration, lowest channel first
  always_comb begin
    grant_any = 1'b0;
    grant_idx = '0;
    for (int c = NUM_CHANNELS - 1; c >= 0; c--) begin
      if (st_reg.ch[c].pend_valid) begin
        grant_any = 1'b1;
        grant_idx = CHAN_BITS'(c);
      end
    end
  end

  assign fifo_port.wr_valid = grant_any;
  assign fifo_port.wr_data  = {grant_idx, st_reg.ch[grant_idx].pend_word};
  assign fifo_port.rd_ready = msg_ready_i;
  assign msg_valid_o        = fifo_port.rd_valid;
  assign msg_channel_o      = fifo_port.rd_data[WORD_BITS-1 -: CHAN_BITS];
  assign msg_kind_o         = fifo_port.rd_data[PAYLOAD_BITS +: KIND_BITS];
  assign msg_payload_o      = fifo_port.rd_data[PAYLOAD_BITS-1:0];

  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      overrun_o[c]    = st_reg.ch[c].overrun;
      in_message_o[c] = st_reg.ch[c].in_msg;
    end
  end

  // ==========================================================================
  // Per-channel receiver and message parser
  always_comb begin
    logic                              emit;
    logic [KIND_BITS+PAYLOAD_BITS-1:0] word;
    logic [15:0]                       hdr;
    logic [KEY_BITS-1:0]               key;
    logic [7:0]                        rx_byte;
    emit    = 1'b0;
    word    = '0;
    hdr     = '0;
    key     = '0;
    rx_byte = '0;
    st_next = st_reg;
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      emit = 1'b0;
      word = '0;
      if (grant_any && fifo_port.wr_ready && grant_idx == CHAN_BITS'(c)) begin
        st_next.ch[c].pend_valid = 1'b0;
      end
      st_next.ch[c].sync = {st_reg.ch[c].sync[1:0], line_i[c]};
      if (st_reg.ch[c].sync[1] == st_reg.ch[c].sync[2]) begin
        st_next.ch[c].line = st_reg.ch[c].sync[2];
      end
      rx_byte = st_reg.ch[c].shift;
      unique case (st_reg.ch[c].rx)
        RX_IDLE: begin
          if (st_reg.ch[c].line == 1'b0) begin
            st_next.ch[c].rx   = RX_START;
            st_next.ch[c].tick = '0;
            st_next.ch[c].idle = '0;
          end else if (st_reg.ch[c].idle != TICK_BITS'(GAP_CYCLES)) begin
            st_next.ch[c].idle = TICK_BITS'(st_reg.ch[c].idle + 1'b1);
          end else if (st_reg.ch[c].in_msg) begin
            st_next.ch[c].in_msg = 1'b0;
            st_next.ch[c].pos    = '0;
            emit = st_reg.ch[c].admit;
            word = make_word(KIND_END, PAYLOAD_BITS'(st_reg.ch[c].pos));
          end
        end
        RX_START: begin
          st_next.ch[c].tick = TICK_BITS'(st_reg.ch[c].tick + 1'b1);
          if (st_reg.ch[c].tick == TICK_BITS'(HALF_BIT_CYCLES - 1)) begin
            st_next.ch[c].tick    = '0;
            st_next.ch[c].bit_idx = '0;
            st_next.ch[c].rx      = st_reg.ch[c].line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          st_next.ch[c].tick = TICK_BITS'(st_reg.ch[c].tick + 1'b1);
          if (st_reg.ch[c].tick == TICK_BITS'(BIT_CYCLES - 1)) begin
            st_next.ch[c].tick    = '0;
            st_next.ch[c].shift   = {st_reg.ch[c].line, st_reg.ch[c].shift[7:1]};
            st_next.ch[c].bit_idx = 3'(st_reg.ch[c].bit_idx + 1'b1);
            if (st_reg.ch[c].bit_idx == 3'h7) begin
              st_next.ch[c].rx = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          st_next.ch[c].tick = TICK_BITS'(st_reg.ch[c].tick + 1'b1);
          if (st_reg.ch[c].tick == TICK_BITS'(BIT_CYCLES - 1)) begin
            st_next.ch[c].tick = '0;
            st_next.ch[c].rx   = RX_IDLE;
            st_next.ch[c].idle = '0;
            if (st_reg.ch[c].line) begin
              st_next.ch[c].in_msg = 1'b1;
              if (st_reg.ch[c].pos != POS_BITS'(MAX_MESSAGES)) begin
                st_next.ch[c].pos = POS_BITS'(st_reg.ch[c].pos + 1'b1);
              end
              if (st_reg.ch[c].pos == POS_BITS'(HDR_FIRST_POS)) begin
                st_next.ch[c].hdr_hi = rx_byte;
                st_next.ch[c].admit  = 1'b0;
              end else if (st_reg.ch[c].pos == POS_BITS'(HDR_SECOND_POS)) begin
                hdr = {st_reg.ch[c].hdr_hi, rx_byte};
                key = header_key(hdr);
                if (st_reg.ch[c].seen[key] ||
                    st_reg.ch[c].distinct != POS_BITS'(MAX_MESSAGES)) begin
                  st_next.ch[c].admit     = 1'b1;
                  st_next.ch[c].seen[key] = 1'b1;
                  if (!st_reg.ch[c].seen[key]) begin
                    st_next.ch[c].distinct = POS_BITS'(st_reg.ch[c].distinct + 1'b1);
                  end
                  emit = 1'b1;
                  // Header keeps id, origin, freshness and length in place.
                  word = make_word(KIND_HEADER, hdr);
                end
              end else if (st_reg.ch[c].admit && st_reg.ch[c].pos <
                           POS_BITS'(DATA_FIRST_POS + MAX_DATA_BYTES)) begin
                emit = 1'b1;
                word = make_word(KIND_DATA, {st_reg.ch[c].pos, 1'b0, rx_byte});
              end
            end
          end
        end
      endcase
      if (emit) begin
        if (st_next.ch[c].pend_valid) begin
          st_next.ch[c].overrun = 1'b1;
        end else begin
          st_next.ch[c].pend_valid = 1'b1;
          st_next.ch[c].pend_word  = word;
        end
      end
    end
    if (reset_i) begin
      st_next = '0;
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        st_next.ch[c].rx   = RX_IDLE;
        st_next.ch[c].sync = 3'h7;
        st_next.ch[c].line = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || ce_i) begin
      st_reg <= st_next;
    end
  end
endmodule // link_message_monitor

// ---- dv/link_message_monitor_sva.sv ----
// Port-level assertions for the link message monitor.
module link_message_monitor_sva
  import link_monitor_pkg::*;
(
  input wire logic                                      sys_clk_i,
  input wire logic                                      reset_i,
  input wire logic                                      ce_i,
  input wire logic [link_monitor_pkg::NUM_CHANNELS-1:0] line_i,
  input wire logic                                      msg_valid_o,
  input wire logic                                      msg_ready_i,
  input wire logic [link_monitor_pkg::CHAN_BITS-1:0]    msg_channel_o,
  input wire logic [link_monitor_pkg::KIND_BITS-1:0]    msg_kind_o,
  input wire logic [link_monitor_pkg::PAYLOAD_BITS-1:0] msg_payload_o,
  input wire logic [link_monitor_pkg::NUM_CHANNELS-1:0] overrun_o,
  input wire logic [link_monitor_pkg::NUM_CHANNELS-1:0] in_message_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Helper state: idle run on channel 0 and headers seen per channel.
  logic [11:0]             idle_cnt_reg;
  logic [NUM_CHANNELS-1:0] hdr_seen_reg;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !line_i[0]) begin
      idle_cnt_reg <= 12'h000;
    end else if (idle_cnt_reg != 12'hfff) begin
      idle_cnt_reg <= idle_cnt_reg + 12'h001;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hdr_seen_reg <= 4'h0;
    end else if (msg_valid_o && msg_ready_i) begin
      if (msg_kind_o == KIND_HEADER) begin
        hdr_seen_reg[msg_channel_o] <= 1'b1;
      end else if (msg_kind_o == KIND_END) begin
        hdr_seen_reg[msg_channel_o] <= 1'b0;
      end
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_reset_clear: assert property ($fell(reset_i) |-> !msg_valid_o && in_message_o == 4'h0)
    else $error("outputs not clear after reset");
  a_head_hold: assert property (msg_valid_o && !msg_ready_i |=> msg_valid_o &&
    $stable(msg_payload_o) && $stable(msg_kind_o) && $stable(msg_channel_o))
    else $error("head word changed while stalled");
  a_kind_legal: assert property (msg_valid_o |-> msg_kind_o != 2'h3)
    else $error("unknown word kind");
  a_data_field: assert property (msg_valid_o && msg_kind_o == KIND_DATA |->
    !msg_payload_o[8] && msg_payload_o[15:9] inside {[7'h02:7'h42]})
    else $error("data position out of range");
  a_end_field: assert property (msg_valid_o && msg_kind_o == KIND_END |->
    msg_payload_o[15:7] == 9'h000 && msg_payload_o[6:0] != 7'h00)
    else $error("bad end word");
  a_gap_close: assert property (idle_cnt_reg == 12'h7d0 |-> !in_message_o[0])
    else $error("message not closed after idle gap");
  a_gap_early: assert property (in_message_o[0] && idle_cnt_reg < 12'h3e8 |=> in_message_o[0])
    else $error("message closed before idle gap");
  a_hdr_first: assert property (msg_valid_o && msg_kind_o == KIND_DATA |->
    hdr_seen_reg[msg_channel_o])
    else $error("data word without header");
  c_header: cover property (msg_valid_o && msg_ready_i && msg_kind_o == KIND_HEADER);
  c_end: cover property (msg_valid_o && msg_ready_i && msg_kind_o == KIND_END);
  c_overrun: cover property ($rose(overrun_o[0]));
endmodule // link_message_monitor_sva

bind link_message_monitor link_message_monitor_sva chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .ce_i(ce_i), .line_i(line_i),
  .msg_valid_o(msg_valid_o), .msg_ready_i(msg_ready_i), .msg_channel_o(msg_channel_o),
  .msg_kind_o(msg_kind_o), .msg_payload_o(msg_payload_o), .overrun_o(overrun_o),
  .in_message_o(in_message_o)
);

// ---- dv/link_unit_model.sv ----
// Behavioural master and slave units driving the four link lines.
module link_unit_model
  import link_monitor_pkg::*;
(
  input  wire logic                                      sys_clk_i,
  output logic [link_monitor_pkg::NUM_CHANNELS-1:0]      line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Line drivers, called on a falling edge.
  initial line_o = 4'hf;
  task automatic put_bit(input int ch, input logic v);
    line_o[ch] = v;
    repeat (BIT_CYCLES) @(negedge sys_clk_i);
  endtask
  task automatic put_byte(input int ch, input logic [7:0] b);
    put_bit(ch, 1'b0);
    for (int i = 0; i < 8; i++) put_bit(ch, b[i]);
    put_bit(ch, 1'b1);
  endtask
  // A slow sender idles stall_bits bit times before its second data byte.
  task automatic send_msg(input int ch, input logic [15:0] hdr, input int n,
                          input logic [7:0] base, input int stall_bits);
    put_byte(ch, hdr[15:8]);
    put_byte(ch, hdr[7:0]);
    for (int i = 0; i < n; i++) begin
      if (i == 1) repeat (stall_bits) put_bit(ch, 1'b1);
      put_byte(ch, base + 8'(i));
    end
    repeat (GAP_BITS) put_bit(ch, 1'b1);
  endtask
  task automatic exchange(input int ch, input logic [4:0] id, input logic [3:0] fresh);
    send_msg(ch, {id, 1'b1, fresh, 6'h00}, 0, 8'h00, 0);
    send_msg(ch, {id, 1'b0, fresh + 4'h1, 6'h00}, 0, 8'h00, 0);
  endtask
endmodule // link_unit_model

// ---- dv/link_message_monitor_test.sv ----
// Self-checking bench for the link message monitor and its line partner.
module link_message_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import link_monitor_pkg::*;
  logic                    sys_clk_i   = 1'b0;
  logic                    reset_i     = 1'b1;
  logic                    ce_i        = 1'b1;
  logic                    msg_ready_i = 1'b1;
  logic [NUM_CHANNELS-1:0] line_w;
  logic                    msg_valid_o;
  logic [CHAN_BITS-1:0]    msg_channel_o;
  logic [KIND_BITS-1:0]    msg_kind_o;
  logic [PAYLOAD_BITS-1:0] msg_payload_o;
  logic [NUM_CHANNELS-1:0] overrun_o;
  logic [NUM_CHANNELS-1:0] in_message_o;
  int                      err_total = 0;
  int                      tests_run = 0;
  logic [WORD_BITS-1:0]    got_q[$];
  logic [WORD_BITS:0]      head_q;
  always #5 sys_clk_i = ~sys_clk_i;
  link_unit_model peer (.sys_clk_i(sys_clk_i), .line_o(line_w));
  link_message_monitor dut (
    .sys_clk_i    (sys_clk_i),
    .reset_i      (reset_i),
    .ce_i         (ce_i),
    .line_i       (line_w),
    .msg_valid_o  (msg_valid_o),
    .msg_ready_i  (msg_ready_i),
    .msg_channel_o(msg_channel_o),
    .msg_kind_o   (msg_kind_o),
    .msg_payload_o(msg_payload_o),
    .overrun_o    (overrun_o),
    .in_message_o (in_message_o)
  );
  // The head word is settled at the falling edge and popped at the next rising edge.
  always @(negedge sys_clk_i) begin
    head_q <= {msg_valid_o, msg_channel_o, msg_kind_o, msg_payload_o};
  end
  always @(posedge sys_clk_i) begin
    if (reset_i == 1'b0 && head_q[WORD_BITS] === 1'b1 && msg_ready_i == 1'b1) begin
      got_q.push_back(head_q[WORD_BITS-1:0]);
    end
  end
  // ==========================================================================
  // Shared checking tasks
  task automatic check(input string what, input logic [WORD_BITS-1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pop_word(output logic [WORD_BITS-1:0] w);
    w = 'x;
    for (int i = 0; i < 3000 && got_q.size() == 0; i++) @(negedge sys_clk_i);
    if (got_q.size() != 0) w = got_q.pop_front();
  endtask
  function automatic logic [WORD_BITS-1:0] word(input int ch, input logic [1:0] k,
                                                input logic [15:0] p);
    return {2'(ch), k, p};
  endfunction
  task automatic expect_msg(input int ch, input logic [15:0] hdr, input int n,
                            input logic [7:0] base, input bit closed);
    logic [WORD_BITS-1:0] w;
    pop_word(w);
    check("header", w, word(ch, KIND_HEADER, hdr));
    for (int i = 0; i < n && i < MAX_DATA_BYTES; i++) begin
      pop_word(w);
      check("data", w, word(ch, KIND_DATA, {7'(i + 2), 1'b0, base + 8'(i)}));
    end
    if (closed) begin
      pop_word(w);
      check("end", w, word(ch, KIND_END, 16'(n + 2)));
    end else begin
      repeat (50) @(negedge sys_clk_i);
      check("left", 20'(got_q.size()), 20'h00000);
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_request();
    peer.send_msg(0, 16'h2cc2, 2, 8'ha5, 9);
    expect_msg(0, 16'h2cc2, 2, 8'ha5, 1'b1);
  endtask
  task automatic t_exchange();
    for (int k = 0; k < 2; k++) begin
      peer.exchange(1, 5'h1f, 4'he + 4'(k));
      expect_msg(1, {5'h1f, 1'b1, 4'he + 4'(k), 6'h00}, 0, 8'h00, 1'b1);
      expect_msg(1, {5'h1f, 1'b0, 4'hf + 4'(k), 6'h00}, 0, 8'h00, 1'b1);
    end
  endtask
  task automatic t_channels();
    logic [WORD_BITS-1:0] w;
    logic [WORD_BITS-1:0] exp[4];
    exp = '{word(2, KIND_HEADER, 16'h8400), word(3, KIND_HEADER, 16'h0000),
            word(2, KIND_END, 16'h0002), word(3, KIND_END, 16'h0002)};
    fork
      peer.send_msg(2, 16'h8400, 0, 8'h00, 0);
      begin
        repeat (500) @(negedge sys_clk_i);
        peer.send_msg(3, 16'h0000, 0, 8'h00, 0);
      end
    join
    foreach (exp[i]) begin
      pop_word(w);
      check("channel word", w, exp[i]);
    end
  endtask
  task automatic t_stall();
    msg_ready_i = 1'b0;
    peer.send_msg(0, 16'h3808, 8, 8'h40, 0);
    check("overrun", 20'(overrun_o), 20'h00001);
    msg_ready_i = 1'b1;
    expect_msg(0, 16'h3808, 8, 8'h40, 1'b0);
  endtask
  // ==========================================================================
  // Sequence, watchdog and verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (110000) @(posedge sys_clk_i);
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(negedge sys_clk_i);
    reset_i = 1'b0;
    t_request();
    t_exchange();
    t_channels();
    peer.send_msg(0, 16'h083f, 66, 8'h10, 0);
    expect_msg(0, 16'h083f, 66, 8'h10, 1'b1);
    t_stall();
    tally_and_finish();
  end
endmodule // link_message_monitor_test
